// ### common/clock_control_pkg.sv
// Package: register map, field layout and timing counts for the clock control block
package clock_control_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] OSC_MODE_ADDR    = 12'h328;  // index 0xCA times four
   localparam logic [11:0] CLK_STATUS_ADDR  = 12'h330;
   localparam logic [11:0] WAKE_CTRL_ADDR   = 12'h334;
   localparam logic [7:0]  OSC_MODE_INDEX   = 8'hCA;
   localparam logic [7:0]  OSC_MODE_RESET   = 8'h00;

   localparam int HIGH_STOP_BIT  = 1;
   localparam int SLOW_SEL_BIT   = 2;
   localparam int SLEEP_BIT      = 3;
   localparam int GREEN_BIT      = 4;

   localparam logic [1:0] BRESP_OKAY   = 2'h0;
   localparam logic [1:0] BRESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Option encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SRC_FAST_RC_ONLY      = 3'b000,
      SRC_FAST_RC_TIMEBASE  = 3'b001,
      SRC_EXT_RC            = 3'b010,
      SRC_WATCH_CRYSTAL     = 3'b011,
      SRC_FAST_CRYSTAL      = 3'b100,
      SRC_MEDIUM_CRYSTAL    = 3'b101
   } high_src_type;

   typedef enum logic [1:0]
   {
      PWR_NORMAL   = 2'b00,
      PWR_SLEEP    = 2'b01,
      PWR_GREEN    = 2'b10,
      PWR_RESERVED = 2'b11
   } power_state_type;

   typedef enum logic [1:0]
   {
      ST_WARMUP  = 2'b00,
      ST_RUN     = 2'b01,
      ST_SLEEP   = 2'b10,
      ST_GREEN   = 2'b11
   } run_state_type;

   // ----------------------------------------------------------------
   // Timing counts, in high-clock cycles
   // ----------------------------------------------------------------
   localparam int          WARMUP_LONG_CYCLES  = 2048;
   localparam int          WARMUP_SHORT_CYCLES = 32;
   localparam int          DIV_MIN_PLAIN       = 1;
   localparam int          DIV_MIN_FILTERED    = 4;
   localparam int          DIV_MAX             = 128;

endpackage : clock_control_pkg

// ### core/system_clock_control.sv
// System clock control: source select, cycle divider, mode register and warm-up
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Without noise filter, divider ratio may be any value from 1 to 128.
// - With noise filter, divider ratio is limited to 4 through 128.
// - Fast and slow clock paths share the same divider ratio.
// - Build option selects one of six high-clock sources.
// - Fast RC alone leaves both oscillator pins as general I/O.
// - Timebase mode dedicates both oscillator pins to the watch crystal.
// - External RC uses only the input pin; output pin stays general I/O.
// - Timebase mode clocks system from fast RC, real time clock from crystal.
// - Fast RC runs only in fast RC alone or timebase modes.
// - Timebase stop bit halts the crystal; fast RC stops only with slow select also set.
// - Mode register holds power state 4:3, slow select 2, stop 1.
// - Stop bit 0 lets high oscillator run; 1 stops it, slow RC runs.
// - Stop bit halts fast RC (in timebase only with slow select set), the timebase crystal, or external oscillator.
// - Slow select 0 picks high clock, 1 picks slow RC clock.
// - Power state 00 normal, 01 sleep, 10 green, 11 reserved.
// - Slow RC stops only in sleep, or green under watch crystal, no watchdog.
// - After any reset, hold execution 2048 high-clock cycles.
// - Sleep wake-up waits 2048 cycles for crystals, 32 for RC sources.
// - Wake from sleep clears the sleep bit automatically.
// - Wake from green clears the green bit automatically.
module system_clock_control
#(
   parameter logic [2:0] HIGH_SRC      = 3'b000,
   parameter int         DIV_RATIO     = 16,
   parameter bit         NOISE_FILTER  = 1'b0,
   parameter int         WARMUP_LONG   = 2048
)
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [11:0]                s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [11:0]                s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       wake_event,
   input  wire logic                       watchdog_enable,
   output logic                            cpu_cycle_en,
   output logic                            cpu_run,
   output logic                            slow_clock_active,
   output logic                            internal_fast_rc_en,
   output logic                            external_osc_en,
   output logic                            internal_slow_rc_en,
   output logic                            rtc_clock_en,
   output logic                            osc_in_pin_gpio,
   output logic                            osc_out_pin_gpio
);
   import clock_control_pkg::*;

   // ----------------------------------------------------------------
   // Build-time choices
   // ----------------------------------------------------------------
   // source decode
   localparam high_src_type SRC = high_src_type'(HIGH_SRC);
   localparam bit IS_FAST_RC  = (SRC == SRC_FAST_RC_ONLY) || (SRC == SRC_FAST_RC_TIMEBASE);
   localparam bit IS_TIMEBASE = (SRC == SRC_FAST_RC_TIMEBASE);
   localparam bit IS_RC_TYPE  = IS_FAST_RC || (SRC == SRC_EXT_RC);
   // Out-of-range ratios are clamped rather than refused, so any build elaborates
   // ratio clamp
   localparam int DIV_LOW  = NOISE_FILTER ? DIV_MIN_FILTERED : DIV_MIN_PLAIN;
   localparam int DIV_EFF  = (DIV_RATIO < DIV_LOW) ? DIV_LOW :
                             (DIV_RATIO > DIV_MAX) ? DIV_MAX : DIV_RATIO;
   localparam logic [6:0] DIV_LAST = 7'(DIV_EFF - 1);
   localparam logic [11:0] LONG_LAST  = 12'(WARMUP_LONG - 1);
   localparam logic [11:0] SHORT_LAST = 12'(WARMUP_SHORT_CYCLES - 1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                 high_stop_r;
   logic                 slow_sel_r;
   logic [1:0]           power_state_r;
   run_state_type        state_r;
   logic [11:0]          warm_cnt_r;
   logic [11:0]          warm_last_r;
   logic [6:0]           div_cnt_r;
   logic                 aw_held_r;
   logic                 w_held_r;
   logic [11:0]          awaddr_r;
   logic [31:0]          wdata_r;
   logic                 wstrb0_r;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Ready pulses one cycle, so a held request is never taken twice
   wire aw_take    = s_axi_awvalid && s_axi_awready;
   wire w_take     = s_axi_wvalid && s_axi_wready;
   wire aw_have    = aw_held_r || aw_take;
   wire w_have     = w_held_r || w_take;
   wire [11:0] wa  = aw_held_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wd  = w_held_r ? wdata_r : s_axi_wdata;
   wire        wb0 = w_held_r ? wstrb0_r : s_axi_wstrb[0];
   wire do_write   = aw_have && w_have && !s_axi_bvalid;
   wire hit_mode_w = (wa == OSC_MODE_ADDR);
   wire mode_wr    = do_write && hit_mode_w && wb0;
   wire ar_take    = s_axi_arvalid && s_axi_arready;

   wire [7:0] mode_image = {3'h0, power_state_r, slow_sel_r, high_stop_r, 1'b0};
   wire [31:0] status_image = {24'h0, 1'b0, (state_r == ST_WARMUP), state_r,
                               internal_fast_rc_en, external_osc_en,
                               internal_slow_rc_en, slow_clock_active};
   wire [31:0] rd_word;
   wire        rd_ok;
   assign rd_ok   = (s_axi_araddr == OSC_MODE_ADDR) || (s_axi_araddr == CLK_STATUS_ADDR);
   assign rd_word = (s_axi_araddr == OSC_MODE_ADDR)   ? {24'h0, mode_image} :
                    (s_axi_araddr == CLK_STATUS_ADDR) ? status_image : 32'h0;

   // ----------------------------------------------------------------
   // Power state sequencing
   // ----------------------------------------------------------------
   wire running    = (state_r == ST_RUN);
   // Reserved code 11 falls into sleep through its low bit
   wire enter_sleep = running && power_state_r[0];
   wire enter_green = running && !power_state_r[0] && power_state_r[1];
   wire warm_done  = (state_r == ST_WARMUP) && (warm_cnt_r == warm_last_r);
   // wake-up warm-up length by oscillator type
   wire [11:0] wake_last = IS_RC_TYPE ? SHORT_LAST : LONG_LAST;
   wire wake_sleep = (state_r == ST_SLEEP) && wake_event;
   wire wake_green = (state_r == ST_GREEN) && wake_event;

   wire osc_off     = (state_r == ST_SLEEP);
   wire fast_rc_nxt = IS_FAST_RC && !osc_off && !(high_stop_r && (slow_sel_r ||
                      !IS_TIMEBASE));
   wire ext_osc_nxt = !IS_FAST_RC && !osc_off && !high_stop_r;
   wire rtc_nxt     = IS_TIMEBASE && !osc_off && !high_stop_r;
   wire slow_rc_nxt = !osc_off && !((state_r == ST_GREEN) &&
                      (SRC == SRC_WATCH_CRYSTAL) && !watchdog_enable);

   // Count restarts whenever the core halts, so the first cycle after wake is whole
   // divider tick
   wire cpu_clock_on = running;
   wire div_wrap    = (div_cnt_r == DIV_LAST);

   // ----------------------------------------------------------------
   // AXI4-Lite slave, write side
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= 12'h000;
         wdata_r       <= 32'h0000_0000;
         wstrb0_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= BRESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take)
         begin
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
         end
         aw_held_r     <= aw_have && !do_write;
         w_held_r      <= w_have && !do_write;
         s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
         s_axi_wready  <= !w_have && !s_axi_bvalid && !s_axi_wready;
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (hit_mode_w || wa == WAKE_CTRL_ADDR) ? BRESP_OKAY
                                                                  : BRESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave, read side
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= BRESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (ar_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? BRESP_OKAY : BRESP_SLVERR;
         end
         else if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode register
   // ----------------------------------------------------------------
   // Wake clear outranks a software write landing in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         high_stop_r   <= 1'b0;
         slow_sel_r    <= 1'b0;
         power_state_r <= PWR_NORMAL;
      end
      else if (wake_sleep)
      begin
         // sleep bit self-clears; wake lands in normal mode
         power_state_r[0] <= 1'b0;
         slow_sel_r       <= 1'b0;
      end
      else if (wake_green)
      begin
         power_state_r[1] <= 1'b0;
      end
      else if (mode_wr)
      begin
         high_stop_r   <= wd[HIGH_STOP_BIT];
         slow_sel_r    <= wd[SLOW_SEL_BIT];
         power_state_r <= wd[GREEN_BIT:SLEEP_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Run state and warm-up
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r     <= ST_WARMUP;
         warm_cnt_r  <= 12'h000;
         warm_last_r <= LONG_LAST;
      end
      else
      begin
         case (state_r)
            ST_WARMUP:
            begin
               warm_cnt_r <= warm_cnt_r + 12'h001;
               if (warm_done)
               begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if (enter_sleep)
               begin
                  state_r <= ST_SLEEP;
               end
               else if (enter_green)
               begin
                  state_r <= ST_GREEN;
               end
            end
            ST_SLEEP:
            begin
               if (wake_event)
               begin
                  state_r     <= ST_WARMUP;
                  warm_cnt_r  <= 12'h000;
                  warm_last_r <= wake_last;
               end
            end
            ST_GREEN:
            begin
               if (wake_event)
               begin
                  state_r <= ST_RUN;
               end
            end
            default:
            begin
               state_r <= ST_WARMUP;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Cycle divider
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_cnt_r    <= 7'h00;
         cpu_cycle_en <= 1'b0;
         cpu_run      <= 1'b0;
      end
      else
      begin
         // one shared ratio for both paths
         div_cnt_r    <= (!cpu_clock_on || div_wrap) ? 7'h00 : div_cnt_r + 7'h01;
         cpu_cycle_en <= cpu_clock_on && div_wrap;
         cpu_run      <= running;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator enables and pin roles
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slow_clock_active   <= 1'b0;
         internal_fast_rc_en <= 1'b0;
         external_osc_en     <= 1'b0;
         internal_slow_rc_en <= 1'b0;
         rtc_clock_en        <= 1'b0;
         osc_in_pin_gpio     <= 1'b0;
         osc_out_pin_gpio    <= 1'b0;
      end
      else
      begin
         slow_clock_active   <= slow_sel_r;
         internal_fast_rc_en <= fast_rc_nxt;
         external_osc_en     <= ext_osc_nxt;
         // timebase crystal feeds the real time clock
         rtc_clock_en        <= rtc_nxt || ((SRC == SRC_WATCH_CRYSTAL) && ext_osc_nxt);
         internal_slow_rc_en <= slow_rc_nxt;
         osc_in_pin_gpio     <= (SRC == SRC_FAST_RC_ONLY);
         osc_out_pin_gpio    <= (SRC == SRC_FAST_RC_ONLY) || (SRC == SRC_EXT_RC);
      end
   end

endmodule : system_clock_control
`default_nettype wire

// ### tb/rc_network_model.sv
// External RC network model: counts oscillations while the block enables it
`timescale 1ns/10ps
`default_nettype none
module rc_network_model
(
   input  wire logic       aclk,
   input  wire logic       osc_enable,
   output logic [7:0]      tick_count
);
   initial tick_count = 8'h00;
   // network hangs on the input pin only
   // no ticks while the stop bit holds it off
   always @(posedge aclk)
   begin
      if (osc_enable)
         tick_count <= tick_count + 8'h01;
   end
endmodule : rc_network_model
`default_nettype wire

// ### tb/system_clock_control_assertions.sv
// Checker: timing relations on the clock control ports, ratio 5, RC source
`timescale 1ns/10ps
`default_nettype none
module system_clock_control_assertions
#(
   parameter int DIV_RATIO   = 5,
   parameter int WARMUP_LONG = 40
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wake_event,
   input wire logic cpu_cycle_en,
   input wire logic cpu_run,
   input wire logic internal_fast_rc_en,
   input wire logic external_osc_en,
   input wire logic internal_slow_rc_en,
   input wire logic rtc_clock_en,
   input wire logic osc_in_pin_gpio,
   input wire logic osc_out_pin_gpio
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Fixed figures below hold for ratio 5 and warm-up 40 only
   a_div_gap: assert property (
      cpu_cycle_en |=> !cpu_cycle_en [*4] ##1 (cpu_cycle_en || !cpu_run))
      else $error("divider pulse spacing wrong");
   a_pulse_run: assert property (cpu_cycle_en |-> cpu_run)
      else $error("cycle pulse while halted");
   a_warmup_len: assert property (
      $rose(aresetn) |-> ##38 !cpu_run ##[1:5] cpu_run)
      else $error("reset warm-up length wrong");
   a_wake_short: assert property (
      wake_event && !internal_slow_rc_en |-> ##24 !cpu_run ##[1:14] cpu_run)
      else $error("sleep wake-up length wrong");
   a_pin_roles: assert property (
      $past(aresetn) |-> !osc_in_pin_gpio && osc_out_pin_gpio)
      else $error("oscillator pin roles wrong");
   a_fast_rc_off: assert property ($past(aresetn) |-> !internal_fast_rc_en)
      else $error("fast RC on with RC source");
   a_rtc_off: assert property (!rtc_clock_en)
      else $error("timebase clock on without timebase");
   a_slow_rc_only: assert property (!internal_slow_rc_en |-> !cpu_run)
      else $error("slow RC stopped while running");
   a_stop_keeps_slow: assert property (
      $past(aresetn) && !external_osc_en && cpu_run |-> internal_slow_rc_en)
      else $error("slow RC stopped with high stop");
endmodule : system_clock_control_assertions
bind system_clock_control system_clock_control_assertions
#(.DIV_RATIO(DIV_RATIO), .WARMUP_LONG(WARMUP_LONG)) u_chk
(.aclk(aclk), .aresetn(aresetn), .wake_event(wake_event), .cpu_cycle_en(cpu_cycle_en),
 .cpu_run(cpu_run), .internal_fast_rc_en(internal_fast_rc_en),
 .external_osc_en(external_osc_en), .internal_slow_rc_en(internal_slow_rc_en),
 .rtc_clock_en(rtc_clock_en), .osc_in_pin_gpio(osc_in_pin_gpio),
 .osc_out_pin_gpio(osc_out_pin_gpio));
`default_nettype wire

// ### tb/test_mcu_system_clock_control.sv
// Testbench: registers, divider, pin roles and power states, RC source
`timescale 1ns/10ps
`default_nettype none
module test_mcu_system_clock_control;
   import clock_control_pkg::*;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, wake_event = 0, watchdog_enable = 0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d, q;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, cyc_en, cpu_run, slow_act;
   logic        frc_en, xosc_en, src_en, rtc_en, in_gpio, out_gpio;
   logic [7:0]  ticks, t0;
   integer      seed = 32'hA0977C59;
   int          bad_count = 0, n_tests = 0, n;
   always #50 aclk = ~aclk;
   system_clock_control #(.HIGH_SRC(SRC_EXT_RC), .DIV_RATIO(5), .NOISE_FILTER(1'b0),
      .WARMUP_LONG(40)) i_dut
   (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wake_event(wake_event), .watchdog_enable(watchdog_enable), .cpu_cycle_en(cyc_en),
    .cpu_run(cpu_run), .slow_clock_active(slow_act), .internal_fast_rc_en(frc_en),
    .external_osc_en(xosc_en), .internal_slow_rc_en(src_en), .rtc_clock_en(rtc_en),
    .osc_in_pin_gpio(in_gpio), .osc_out_pin_gpio(out_gpio));
   rc_network_model i_osc (.aclk(aclk), .osc_enable(xosc_en), .tick_count(ticks));
   task give_verdict;
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end
      while (bvalid !== 1'b1);
      bready <= 0;
      check("write response", BRESP_OKAY, bresp);
   endtask : wr
   task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end
      while (rvalid !== 1'b1);
      v = rdata; rr = rresp; rready <= 0;
   endtask : rd
   task pulses(output int k);
      k = 0;
      repeat (50) begin @(posedge aclk); if (cyc_en === 1'b1) k++; end
   endtask : pulses
   task wake_wait;
      @(posedge aclk); wake_event <= 1;
      @(posedge aclk); wake_event <= 0;
      n = 0;
      while (!(cpu_run === 1'b1) && n < 300) begin @(posedge aclk); n++; end
      check("wake within limit", 1, n < 300);
   endtask : wake_wait
   // Watchdog, some 20000 cycles against about 400 needed
   initial begin #(100 * 20000); bad_count++; give_verdict(); end
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      repeat (30) @(posedge aclk);
      check("run in warm-up", 0, cpu_run);
      repeat (20) @(posedge aclk);
      check("run after warm-up", 1, cpu_run);
      check("pin roles", 2'b01, {in_gpio, out_gpio});
      check("fast RC and rtc", 0, {frc_en, rtc_en});
      rd(OSC_MODE_ADDR, q, r);
      check("mode reset", OSC_MODE_RESET, q);
      $display("test reset done");
      for (int i = 0; i < 10; i++)
      begin
         d = (i == 0) ? 32'hFFFFFFE7 : $random(seed) & 32'hFFFFFFE7;
         watchdog_enable <= d[31];
         wr(OSC_MODE_ADDR, d);
         repeat (2) @(posedge aclk);
         rd(OSC_MODE_ADDR, q, r);
         check("mode readback", d & 32'h06, q);
         check("mode read resp", BRESP_OKAY, r);
         check("slow select", d[2], slow_act);
         check("high stop", !d[1], xosc_en);
      end
      $display("test register done");
      wr(OSC_MODE_ADDR, 32'h0);
      pulses(n);
      check("normal pulses", 10, n);
      wr(OSC_MODE_ADDR, 32'h4);
      pulses(n);
      check("slow pulses", 10, n);
      wr(OSC_MODE_ADDR, 32'h2);
      repeat (2) @(posedge aclk);
      t0 = ticks;
      repeat (20) @(posedge aclk);
      check("oscillator halted", t0, ticks);
      check("slow RC running", 1, src_en);
      wr(OSC_MODE_ADDR, 32'h0);
      rd(12'h100, q, r);
      check("unmapped resp", BRESP_SLVERR, r);
      check("unmapped data", 0, q);
      t0 = ticks;
      repeat (10) @(posedge aclk);
      check("oscillator running", 8'(t0 + 8'h0A), ticks);
      $display("test divider and stop done");
      wr(OSC_MODE_ADDR, 32'h8);
      repeat (4) @(posedge aclk);
      check("sleep state", 3'b000, {cpu_run, src_en, xosc_en});
      wake_wait();
      check("wake length", 1, n >= 28 && n <= 40);
      rd(OSC_MODE_ADDR, q, r);
      check("sleep cleared", 0, q);
      wr(OSC_MODE_ADDR, 32'h14);
      repeat (4) @(posedge aclk);
      check("green state", 2'b01, {cpu_run, src_en});
      wake_wait();
      rd(OSC_MODE_ADDR, q, r);
      check("green cleared", 32'h4, q);
      rd(CLK_STATUS_ADDR, q, r);
      check("status word", 32'h17, q);
      check("status resp", BRESP_OKAY, r);
      $display("test power states done");
      give_verdict();
   end
endmodule : test_mcu_system_clock_control
`default_nettype wire
